/* File: design/ppps_pair_decode.sv */
// one pairing field decoder: maps a 2-bit code to a voltage phase
// assumes the caller passes the phase owning the current channel
`timescale 1ns/1ps
`default_nettype none
module ppps_pair_decode (
    input  wire logic [1:0]              code,     // pairing field
    input  wire ppps_pkg::ppps_phase_type own,     // current's phase
    output ppps_pkg::ppps_phase_type     voltage   // chosen voltage
);
    // 00 own, 01 next, 10 two after; reserved 11 behaves as 00
    wire [1:0] step = (code == 2'h3) ? 2'h0 : code;
    wire [2:0] sum  = {1'b0, own} + {1'b0, step};
    wire [1:0] wrap = (sum >= 3'h3) ? 2'(sum - 3'h3) : sum[1:0];
    assign voltage = ppps_pkg::ppps_phase_type'(wrap);
endmodule
`default_nettype wire

/* File: design/ppps_params.svh */
// constants for the power path phase select register bank
// assumes inclusion by the package and design files by bare name
`ifndef PPPS_PARAMS_SVH
`define PPPS_PARAMS_SVH
`define PPPS_ADDR_W         16
`define PPPS_GEN_CFG_ADDR   16'he618
`define PPPS_MEAS_MODE_ADDR 16'he700
`define PPPS_SOFT_RESET_TRIGGER_BIT      7
`define PPPS_PAIR_A_LO      8
`define PPPS_PAIR_B_LO      10
`define PPPS_PAIR_C_LO      12
`define PPPS_PEAK_LO        2
`define PPPS_GEN_CFG_RST    16'h0000
`define PPPS_GEN_CFG_MASK   16'h3f80
`define PPPS_MEAS_MODE_RST  8'h1c
`define PPPS_MEAS_MODE_MASK 8'h1c
`define PPPS_RST_CYCLES     4'h8
`endif

/* File: design/ppps_pkg.sv */
// types for the power path phase select register bank
// assumes ppps_params.svh is on the include path
`include "ppps_params.svh"
package ppps_pkg;
    typedef enum logic [1:0] {
        PPPS_PH_A = 2'h0,
        PPPS_PH_B = 2'h1,
        PPPS_PH_C = 2'h2
    } ppps_phase_type;
    typedef enum logic [1:0] {
        PPPS_IDLE  = 2'h1,
        PPPS_RESET = 2'h2
    } ppps_state_type;
endpackage

/* File: design/ppps_top.sv */
// power path phase select register bank: general config upper bits
// and measurement mode; assumes a plain single-cycle register port
`timescale 1ns/1ps
`default_nettype none
`include "ppps_params.svh"
module ppps_top (
    input  wire logic                    ref_clk,     // 20 MHz clock
    input  wire logic                    sys_rst,     // async, high
    input  wire logic [`PPPS_ADDR_W-1:0] reg_addr,    // register address
    input  wire logic [15:0]             reg_wdata,   // write data
    input  wire logic                    reg_wr,      // write strobe
    input  wire logic                    reg_rd,      // read strobe
    output logic      [15:0]             reg_rdata,   // read data
    output logic                         soft_rst,    // device reset level
    output ppps_pkg::ppps_phase_type     volt_sel_a,  // voltage for I_A
    output ppps_pkg::ppps_phase_type     volt_sel_b,  // voltage for I_B
    output ppps_pkg::ppps_phase_type     volt_sel_c,  // voltage for I_C
    output logic      [2:0]              peak_phase_select // peak sources
);
    logic [15:0] cfg_q, cfg_d;
    logic [7:0]  mode_q, mode_d;
    logic [15:0] rdata_q, rdata_d;
    logic [3:0]  cnt_q, cnt_d;
    ppps_pkg::ppps_state_type st_q, st_d;

    wire hit_cfg  = (reg_addr == `PPPS_GEN_CFG_ADDR);
    wire hit_mode = (reg_addr == `PPPS_MEAS_MODE_ADDR);
    wire in_rst   = (st_q == ppps_pkg::PPPS_RESET);
    wire start    = reg_wr && hit_cfg
                    && reg_wdata[`PPPS_SOFT_RESET_TRIGGER_BIT];
    wire done     = in_rst && (cnt_q == `PPPS_RST_CYCLES - 4'h1);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ppps_pkg::PPPS_IDLE: begin
                cnt_d = 4'h0;
                if (start) begin
                    st_d = ppps_pkg::PPPS_RESET;
                end
            end
            ppps_pkg::PPPS_RESET: begin
                cnt_d = cnt_q + 4'h1;
                if (done) begin
                    st_d  = ppps_pkg::PPPS_IDLE;
                    cnt_d = 4'h0;
                end
            end
            default: begin
                st_d  = ppps_pkg::PPPS_IDLE;
                cnt_d = 4'h0;
            end
        endcase
    end

    // writes ignored while reset runs; reserved bits masked to zero
    always_comb begin
        cfg_d  = cfg_q;
        mode_d = mode_q;
        if (done) begin
            cfg_d  = `PPPS_GEN_CFG_RST;
            mode_d = `PPPS_MEAS_MODE_RST;
        end else if (reg_wr && !in_rst && hit_cfg) begin
            cfg_d = reg_wdata & `PPPS_GEN_CFG_MASK;
        end else if (reg_wr && !in_rst && hit_mode) begin
            mode_d = reg_wdata[7:0] & `PPPS_MEAS_MODE_MASK;
        end
    end

    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd && hit_cfg) begin
            rdata_d = cfg_q;
        end else if (reg_rd && hit_mode) begin
            rdata_d = {8'h00, mode_q};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q    <= ppps_pkg::PPPS_IDLE;
            cnt_q   <= 4'h0;
            cfg_q   <= `PPPS_GEN_CFG_RST;
            mode_q  <= `PPPS_MEAS_MODE_RST;
            rdata_q <= 16'h0000;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            cfg_q   <= cfg_d;
            mode_q  <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign soft_rst  = in_rst;
    assign peak_phase_select =
        mode_q[`PPPS_PEAK_LO +: 3];

    ppps_pair_decode u_dec_a (
        .code    (cfg_q[`PPPS_PAIR_A_LO +: 2]),
        .own     (ppps_pkg::PPPS_PH_A),
        .voltage (volt_sel_a)
    );
    ppps_pair_decode u_dec_b (
        .code    (cfg_q[`PPPS_PAIR_B_LO +: 2]),
        .own     (ppps_pkg::PPPS_PH_B),
        .voltage (volt_sel_b)
    );
    ppps_pair_decode u_dec_c (
        .code    (cfg_q[`PPPS_PAIR_C_LO +: 2]),
        .own     (ppps_pkg::PPPS_PH_C),
        .voltage (volt_sel_c)
    );

    // soft reset sequencing
    a_reset_length: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(soft_rst) |-> soft_rst [*8] ##1 !soft_rst)
        else $error("soft reset length wrong");
    a_soft_reset_trigger_start: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        start && !in_rst |=> soft_rst)
        else $error("soft reset not started");
    a_cnt_idle: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !in_rst |-> cnt_q == 4'h0)
        else $error("reset counter not parked");
    a_state_legal: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        st_q == ppps_pkg::PPPS_IDLE || in_rst)
        else $error("reset state illegal");
    a_soft_reset_trigger_clears: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(soft_rst) |-> cfg_q == `PPPS_GEN_CFG_RST
            && mode_q == `PPPS_MEAS_MODE_RST)
        else $error("soft reset left state");
    a_peak_restored: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(soft_rst) |-> peak_phase_select == 3'h7)
        else $error("peak select not restored");
    a_rst_blocks_wr: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        in_rst && !done |=> $stable(cfg_q) && $stable(mode_q))
        else $error("write landed during soft reset");

    // pairing field decode
    a_pair_a_map: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[9:8] == 2'h1 |-> volt_sel_a == ppps_pkg::PPPS_PH_B)
        else $error("phase a pairing wrong");
    a_pair_a_far: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[9:8] == 2'h2 |-> volt_sel_a == ppps_pkg::PPPS_PH_C)
        else $error("phase a far pairing wrong");
    a_pair_a_rsvd: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[9:8] inside {2'h0, 2'h3} |-> volt_sel_a == ppps_pkg::PPPS_PH_A)
        else $error("phase a own pairing wrong");
    a_pair_b_next: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[11:10] == 2'h1 |-> volt_sel_b == ppps_pkg::PPPS_PH_C)
        else $error("phase b next pairing wrong");
    a_pair_b_map: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[11:10] == 2'h2 |-> volt_sel_b == ppps_pkg::PPPS_PH_A)
        else $error("phase b pairing wrong");
    a_pair_b_rsvd: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[11:10] inside {2'h0, 2'h3} |-> volt_sel_b == ppps_pkg::PPPS_PH_B)
        else $error("phase b own pairing wrong");
    a_pair_c_next: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[13:12] == 2'h1 |-> volt_sel_c == ppps_pkg::PPPS_PH_A)
        else $error("phase c next pairing wrong");
    a_pair_c_far: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[13:12] == 2'h2 |-> volt_sel_c == ppps_pkg::PPPS_PH_B)
        else $error("phase c far pairing wrong");
    a_pair_c_map: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        cfg_q[13:12] inside {2'h0, 2'h3} |-> volt_sel_c == ppps_pkg::PPPS_PH_C)
        else $error("phase c pairing wrong");

    // register port
    a_peak_write: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && hit_mode && !in_rst && !done
        |=> peak_phase_select == $past(reg_wdata[4:2]))
        else $error("peak select not stored");
    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        mode_q[7:5] == 3'h0 && mode_q[1:0] == 2'h0 && cfg_q[15:14] == 2'h0)
        else $error("reserved bits set");
    a_cfg_write: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && hit_cfg && !in_rst
        |=> cfg_q == ($past(reg_wdata) & `PPPS_GEN_CFG_MASK))
        else $error("config write not stored");
    a_cfg_readback: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == 16'he618 |=> reg_rdata == $past(cfg_q))
        else $error("config readback wrong");
    a_mode_readback: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        reg_rd && hit_mode |=> reg_rdata == {8'h00, $past(mode_q)})
        else $error("mode readback wrong");
    a_unmapped_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        reg_rd && !hit_cfg && !hit_mode |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* File: sim/ppps_tb_top.sv */
// bench for the power path phase select register bank
// assumes ppps_pkg and ppps_top are compiled before it
`timescale 1ns/1ps
`default_nettype none
module ppps_tb_top;
    logic                     ref_clk, sys_rst, reg_wr, reg_rd;
    logic [15:0]              reg_addr, reg_wdata, reg_rdata;
    logic                     soft_rst;
    logic [2:0]               peak;
    ppps_pkg::ppps_phase_type va, vb, vc;
    int                       bad_count = 0;
    int                       samples_checked = 0;
    int                       n;
    logic [7:0]               mv [4] = '{8'hff, 8'h04, 8'h14, 8'h00};
    ppps_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .soft_rst(soft_rst),
        .volt_sel_a(va), .volt_sel_b(vb), .volt_sel_c(vc),
        .peak_phase_select(peak));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h not %h", $time, got, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task sel(input logic [1:0] a, b, c, input logic [2:0] p);
        #1 chk({15'h0, soft_rst}, 16'h0000);
        chk({14'h0, va}, {14'h0, a});
        chk({14'h0, vb}, {14'h0, b});
        chk({14'h0, vc}, {14'h0, c});
        chk({13'h0, peak}, {13'h0, p});
    endtask
    function automatic logic [1:0] pick(input int own, input int code);
        return (code == 3) ? 2'(own) : 2'((own + code) % 3);
    endfunction
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        sel(2'h0, 2'h1, 2'h2, 3'h7);
        rd(16'he618, 16'h0000);
        rd(16'he700, 16'h001c);
        for (int c = 0; c < 4; c++) begin
            wr(16'he618, {2'h3, c[1:0], c[1:0], c[1:0], 8'h7f});
            sel(pick(0, c), pick(1, c), pick(2, c), 3'h7);
            rd(16'he618, {2'h0, c[1:0], c[1:0], c[1:0], 8'h00});
        end
        foreach (mv[i]) begin
            wr(16'he700, {8'h00, mv[i]});
            rd(16'he700, {8'h00, mv[i] & 8'h1c});
            sel(2'h0, 2'h1, 2'h2, mv[i][4:2]);
        end
        wr(16'he701, 16'hffff);
        rd(16'he701, 16'h0000);
        rd(16'he700, 16'h0000);
        wr(16'he618, 16'h1500);
        sel(2'h1, 2'h2, 2'h0, 3'h0);
        wr(16'he618, 16'h1580);
        n = 0;
        repeat (20) begin
            #1 if (soft_rst === 1'b1) n++;
            @(posedge ref_clk);
        end
        chk(16'(n), 16'h0008);
        rd(16'he618, 16'h0000);
        rd(16'he700, 16'h001c);
        sel(2'h0, 2'h1, 2'h2, 3'h7);
        complete_run;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        bad_count++;
        complete_run;
    end
endmodule
`default_nettype wire
